/* dea_pkg.sv */
// What this block does
// - address/data direct; control only via pointer indirection
// - address is 7 bits, bit 7 reads zero
// - program enable low blocks write launch, not a running write
// - program start begins write, hardware clears it
// - start without prior enable does nothing
// - read enable low blocks read launch, not a running read
// - read start reads addressed byte, then clears
// - read start without prior enable does nothing
// - fetched byte appears in data register
// - data register holds byte until next read or software write to it
// - array holds 128 bytes, one per operation
// - write end sets flag, software clears it
package dea_pkg;
   localparam int          ADDR_W           = 7;
   localparam int          DEPTH            = 128;
   localparam logic [7:0]  SEC0_ADDR_OFS    = 8'h20;
   localparam logic [7:0]  SEC0_DATA_OFS    = 8'h21;
   localparam logic [7:0]  SEC0_PTR1_LO_OFS = 8'h22;
   localparam logic [7:0]  SEC0_PTR1_HI_OFS = 8'h23;
   localparam logic [7:0]  SEC0_IND1_OFS    = 8'h24;
   localparam logic [7:0]  SEC0_PTR2_LO_OFS = 8'h25;
   localparam logic [7:0]  SEC0_PTR2_HI_OFS = 8'h26;
   localparam logic [7:0]  SEC0_IND2_OFS    = 8'h27;
   localparam logic [7:0]  CTRL_PTR_LO      = 8'h40;
   localparam logic [7:0]  CTRL_PTR_HI      = 8'h01;
   localparam int          BIT_RD_START     = 0;
   localparam int          BIT_RD_EN        = 1;
   localparam int          BIT_WR_START     = 2;
   localparam int          BIT_WR_EN        = 3;
   localparam logic [3:0]  CTRL_RESET       = 4'h0;
   localparam logic [7:0]  REG_RESET        = 8'h00;
   localparam int          WR_SUB_PERIODS   = 4;
   localparam int          SUB_DIV          = 8;
endpackage

/* dea_mem_if.sv */
`timescale 1ns/1ps
interface dea_mem_if;
   logic       we;
   logic       re;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output we, output re, output addr, output wdata, input rdata);
   modport mem  (input we, input re, input addr, input wdata, output rdata);
endinterface

/* dea_mem.sv */
`timescale 1ns/1ps
module dea_mem #(
   parameter int DEPTH = 128
) (
   input  wire logic core_clk,
   dea_mem_if.mem    port
);
   logic [7:0] array_q [DEPTH];
   logic [7:0] rdata_q;
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         array_q[port.addr] <= port.wdata;
      end
      if (port.re) begin
         rdata_q <= array_q[port.addr];
      end
   end
   assign port.rdata = rdata_q;
endmodule

/* dea_access.sv */
`timescale 1ns/1ps
module dea_access
   import dea_pkg::*;
#(
   parameter int WR_PERIODS = dea_pkg::WR_SUB_PERIODS,
   parameter int SUB_DIVIDE = dea_pkg::SUB_DIV
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       write_done_clr,
   output logic            write_done_flag,
   output logic            busy
);
   import dea_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RDWAIT, ST_WRITE} dea_state_type;

   typedef struct packed {
      dea_state_type state;
      logic [6:0]    addr;
      logic [7:0]    data;
      logic [3:0]    ctrl;
      logic [7:0]    p1_lo;
      logic [7:0]    p1_hi;
      logic [7:0]    p2_lo;
      logic [7:0]    p2_hi;
      logic [7:0]    div;
      logic [7:0]    sub_cnt;
      logic          done;
      logic [7:0]    rdata;
   } dea_regs_type;

   dea_regs_type r_q, r_d;
   dea_mem_if    mif ();

   // true when a pointer pair selects the control register
   function automatic logic at_ctrl(input logic [7:0] lo, input logic [7:0] hi);
      return (lo == CTRL_PTR_LO) && (hi == CTRL_PTR_HI);
   endfunction

   logic       ctrl_wr;
   logic       ctrl_hit;
   logic       sub_tick;
   logic [3:0] wr_val;

   always_comb begin
      ctrl_hit = 1'b0;
      if (sfr_addr == SEC0_IND1_OFS) begin
         ctrl_hit = at_ctrl(r_q.p1_lo, r_q.p1_hi);
      end else if (sfr_addr == SEC0_IND2_OFS) begin
         ctrl_hit = at_ctrl(r_q.p2_lo, r_q.p2_hi);
      end
      ctrl_wr  = sfr_wr && ctrl_hit;
      wr_val   = sfr_wdata[3:0];
      sub_tick = (r_q.div == 8'(SUB_DIVIDE - 1));
   end

   always_comb begin
      r_d       = r_q;
      mif.we    = 1'b0;
      mif.re    = 1'b0;
      mif.addr  = r_q.addr;
      mif.wdata = r_q.data;
      r_d.div   = sub_tick ? 8'h00 : r_q.div + 8'h01;

      if (sfr_wr) begin
         unique case (sfr_addr)
            SEC0_ADDR_OFS:    r_d.addr  = sfr_wdata[6:0];
            SEC0_DATA_OFS:    r_d.data  = sfr_wdata;
            SEC0_PTR1_LO_OFS: r_d.p1_lo = sfr_wdata;
            SEC0_PTR1_HI_OFS: r_d.p1_hi = sfr_wdata;
            SEC0_PTR2_LO_OFS: r_d.p2_lo = sfr_wdata;
            SEC0_PTR2_HI_OFS: r_d.p2_hi = sfr_wdata;
            default: ;
         endcase
      end

      if (ctrl_wr) begin
         r_d.ctrl[BIT_WR_EN] = wr_val[BIT_WR_EN];
         r_d.ctrl[BIT_RD_EN] = wr_val[BIT_RD_EN];
         // start only sticks if enable was already high
         r_d.ctrl[BIT_WR_START] = r_q.ctrl[BIT_WR_START] |
                                  (wr_val[BIT_WR_START] & r_q.ctrl[BIT_WR_EN]);
         r_d.ctrl[BIT_RD_START] = r_q.ctrl[BIT_RD_START] |
                                  (wr_val[BIT_RD_START] & r_q.ctrl[BIT_RD_EN]);
      end

      if (write_done_clr) begin
         r_d.done = 1'b0;
      end

      unique case (r_q.state)
         ST_IDLE: begin
            if (r_q.ctrl[BIT_WR_START] && r_q.ctrl[BIT_WR_EN]) begin
               r_d.state   = ST_WRITE;
               r_d.sub_cnt = 8'h00;
            end else if (r_q.ctrl[BIT_RD_START] && r_q.ctrl[BIT_RD_EN]) begin
               mif.re    = 1'b1;
               r_d.state = ST_READ;
            end else if (r_q.ctrl[BIT_WR_START] || r_q.ctrl[BIT_RD_START]) begin
               // enable dropped before launch: abandon the request
               r_d.ctrl[BIT_WR_START] = r_q.ctrl[BIT_WR_EN] ? r_d.ctrl[BIT_WR_START] : 1'b0;
               r_d.ctrl[BIT_RD_START] = r_q.ctrl[BIT_RD_EN] ? r_d.ctrl[BIT_RD_START] : 1'b0;
            end
         end
         ST_READ: begin
            r_d.state = ST_RDWAIT;
         end
         ST_RDWAIT: begin
            r_d.data               = mif.rdata;
            r_d.ctrl[BIT_RD_START] = 1'b0;
            r_d.state              = ST_IDLE;
         end
         ST_WRITE: begin
            if (sub_tick) begin
               r_d.sub_cnt = r_q.sub_cnt + 8'h01;
               if (r_q.sub_cnt == 8'(WR_PERIODS - 1)) begin
                  mif.we                 = 1'b1;
                  r_d.ctrl[BIT_WR_START] = 1'b0;
                  r_d.done               = 1'b1;
                  r_d.state              = ST_IDLE;
               end
            end
         end
      endcase

      r_d.rdata = 8'h00;
      if (sfr_rd) begin
         unique case (sfr_addr)
            SEC0_ADDR_OFS:    r_d.rdata = {1'b0, r_d.addr};
            SEC0_DATA_OFS:    r_d.rdata = r_d.data;
            SEC0_PTR1_LO_OFS: r_d.rdata = r_d.p1_lo;
            SEC0_PTR1_HI_OFS: r_d.rdata = r_d.p1_hi;
            SEC0_PTR2_LO_OFS: r_d.rdata = r_d.p2_lo;
            SEC0_PTR2_HI_OFS: r_d.rdata = r_d.p2_hi;
            default:          r_d.rdata = ctrl_hit ? {4'h0, r_d.ctrl} : 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         r_q       <= '0;
         r_q.state <= ST_IDLE;
         r_q.ctrl  <= CTRL_RESET;
         r_q.data  <= REG_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   dea_mem #(
      .DEPTH (DEPTH)
   ) u_mem (
      .core_clk (core_clk),
      .port     (mif)
   );

   assign sfr_rdata       = r_q.rdata;
   assign write_done_flag = r_q.done;
   assign busy            = (r_q.state != ST_IDLE);
endmodule

/* dea_checker.sv */
`timescale 1ns/1ps
module dea_checker #(
   parameter int WR_PERIODS = 4,
   parameter int SUB_DIVIDE = 8
) (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       write_done_clr,
   input wire logic       write_done_flag,
   input wire logic       busy
);
   import dea_pkg::*;
   localparam int BMAX = WR_PERIODS * SUB_DIVIDE + SUB_DIVIDE + 8;
   logic [15:0] ptr_q;
   logic        st;
   assign st = sfr_wr && sfr_addr == SEC0_IND1_OFS && (sfr_wdata[0] || sfr_wdata[2]);
   always_ff @(posedge core_clk) begin
      if (sfr_wr && sfr_addr == SEC0_PTR1_LO_OFS) ptr_q[7:0] <= sfr_wdata;
      if (sfr_wr && sfr_addr == SEC0_PTR1_HI_OFS) ptr_q[15:8] <= sfr_wdata;
      if (rst) ptr_q <= 16'h0000;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_idle; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_ad7; sfr_rd && sfr_addr == SEC0_ADDR_OFS |=> !sfr_rdata[7]; endproperty
   a_ad7: assert property (p_ad7) else $error("address bit 7 set");
   property p_up0; sfr_rd && sfr_addr == SEC0_IND1_OFS && ptr_q == {CTRL_PTR_HI, CTRL_PTR_LO}
      |=> sfr_rdata[7:4] == 4'h0; endproperty
   a_up0: assert property (p_up0) else $error("control upper bits set");
   property p_keep; write_done_flag && !write_done_clr |=> write_done_flag; endproperty
   a_keep: assert property (p_keep) else $error("done flag lost");
   property p_clr; write_done_clr && !busy && !$past(busy) |=> !write_done_flag; endproperty
   a_clr: assert property (p_clr) else $error("done flag not cleared");
   property p_set; $rose(write_done_flag) |-> $past(busy); endproperty
   a_set: assert property (p_set) else $error("done flag without cycle");
   property p_start; $rose(busy) |-> $past(st) || $past(st, 2) || $past(st, 3); endproperty
   a_start: assert property (p_start) else $error("cycle without start");
   property p_bound; $rose(busy) |-> ##[1:BMAX] !busy; endproperty
   a_bound: assert property (p_bound) else $error("cycle never ends");
   c_wdone: cover property ($rose(write_done_flag));
   c_busy: cover property ($fell(busy));
   c_ctl: cover property (sfr_rd && sfr_addr == SEC0_IND1_OFS);
endmodule
bind dea_access dea_checker #(.WR_PERIODS(WR_PERIODS), .SUB_DIVIDE(SUB_DIVIDE)) u_chk (.*);

/* dea_cpu.sv */
`timescale 1ns/1ps
module dea_cpu (
   input  wire logic       core_clk,
   output logic            sfr_wr,
   output logic            sfr_rd,
   output logic      [7:0] sfr_addr,
   output logic      [7:0] sfr_wdata,
   input  wire logic [7:0] sfr_rdata
);
   logic [7:0] q;
   initial {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h00000;
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, ~w, a, v};
      @(negedge core_clk);
      q = sfr_rdata;
      // released bus shows no stale value
      {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {2'b00, ~a, ~v};
   endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import dea_pkg::*;
   logic        core_clk = 1'b0, rst = 1'b1, write_done_clr = 1'b0;
   logic        sfr_wr, sfr_rd, write_done_flag, busy;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, d;
   logic [31:0] lfsr = 32'h25E0;
   int          num_errors = 0, compares = 0;
   always #20 core_clk = ~core_clk;
   dea_access #(.WR_PERIODS(2), .SUB_DIVIDE(3)) DUT (.*);
   dea_cpu cpu (.*);
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic poll(input int b);
      for (int n = 0; n < 40 && (n == 0 || cpu.q[b] !== 1'b0); n++)
         cpu.acc(1'b0, SEC0_IND1_OFS, 8'h00);
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      chk({6'h00, busy, write_done_flag}, 8'h00);
      cpu.acc(1'b1, SEC0_PTR1_LO_OFS, CTRL_PTR_LO);
      cpu.acc(1'b1, SEC0_PTR1_HI_OFS, CTRL_PTR_HI);
      cpu.acc(1'b1, SEC0_ADDR_OFS, 8'hFF);
      cpu.acc(1'b0, SEC0_ADDR_OFS, 8'h00);
      chk(cpu.q, 8'h7F);
      for (int i = 0; i < 2; i++) begin
         cpu.acc(1'b1, SEC0_IND1_OFS, i ? 8'hF1 : 8'hF4);
         cpu.acc(1'b0, SEC0_IND1_OFS, 8'h00);
         chk(cpu.q, {4'h0, CTRL_RESET});
      end
      cpu.acc(1'b1, SEC0_PTR2_LO_OFS, CTRL_PTR_LO);
      cpu.acc(1'b1, SEC0_PTR2_HI_OFS, CTRL_PTR_HI);
      cpu.acc(1'b1, SEC0_IND2_OFS, 8'h0A);
      cpu.acc(1'b0, SEC0_IND2_OFS, 8'h00);
      chk(cpu.q, 8'h0A);
      cpu.acc(1'b0, SEC0_IND1_OFS, 8'h00);
      chk(cpu.q, 8'h0A);
      cpu.acc(1'b1, SEC0_IND2_OFS, 8'h00);
      // let the sub clock divider run a few periods before any write
      repeat (6) @(negedge core_clk);
      for (int i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         d = lfsr[15:8];
         cpu.acc(1'b1, SEC0_ADDR_OFS, {1'b0, lfsr[6:0]});
         cpu.acc(1'b1, SEC0_DATA_OFS, d);
         cpu.acc(1'b1, SEC0_IND1_OFS, 8'h08);
         cpu.acc(1'b1, SEC0_IND1_OFS, 8'h0C);
         poll(2);
         chk(cpu.q, 8'h08);
         chk({7'h00, write_done_flag}, 8'h01);
         write_done_clr = 1'b1;
         @(negedge core_clk);
         write_done_clr = 1'b0;
         chk({7'h00, write_done_flag}, 8'h00);
         cpu.acc(1'b1, SEC0_DATA_OFS, ~d);
         cpu.acc(1'b1, SEC0_IND1_OFS, 8'h02);
         cpu.acc(1'b1, SEC0_IND1_OFS, 8'h03);
         poll(0);
         chk(cpu.q, 8'h02);
         cpu.acc(1'b0, SEC0_DATA_OFS, 8'h00);
         chk(cpu.q, d);
         cpu.acc(1'b1, SEC0_IND1_OFS, 8'h00);
         cpu.acc(1'b0, SEC0_DATA_OFS, 8'h00);
         chk(cpu.q, d);
      end
      stop_test();
   end
endmodule
